// ==== core/dosl_pkg.sv ====
// Constants, register map and strap field layout of the drive option strap logic.
// Assumes a single 100 MHz core clock and a plain register port of byte addresses.
package dosl_pkg;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    localparam logic [ADDR_W-1:0] SHUNT_OFS  = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;

    // ------------------------------------------------------------------
    // Shunt register fields (1 = strap fitted)
    // ------------------------------------------------------------------
    localparam int unsigned SHUNT_W       = 16;
    localparam int unsigned F_SEL_A       = 0;
    localparam int unsigned F_SEL_D       = 3;
    localparam int unsigned F_FORCE       = 4;
    localparam int unsigned F_WFF_STD     = 5;
    localparam int unsigned F_WFF_CONT    = 6;
    localparam int unsigned F_PROT_HON    = 7;
    localparam int unsigned F_PROT_IGN    = 8;
    localparam int unsigned F_LED_SEL     = 9;
    localparam int unsigned F_LED_USE_A   = 10;
    localparam int unsigned F_LED_USE_B   = 11;
    localparam int unsigned F_FOURTH_EN   = 12;
    localparam int unsigned F_DOOR_LOCK   = 13;
    localparam int unsigned F_STEP_SAVE   = 14;
    localparam int unsigned F_STEP_HOLD   = 15;

    // Factory set: select a, std write gate, honour protect, led from select,
    // fourth select enabled, stepper held
    localparam logic [SHUNT_W-1:0] SHUNT_RST = 16'h92A1;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int unsigned S_ENABLED    = 0;
    localparam int unsigned S_STRAPPED   = 1;
    localparam int unsigned S_LED        = 2;
    localparam int unsigned S_STEP_HOLD  = 3;
    localparam int unsigned S_WFF_BLOCK  = 4;
    localparam int unsigned S_WR_INHIBIT = 5;
    localparam int unsigned S_WR_GATE    = 6;
    localparam int unsigned S_DOOR_LOCK  = 7;
    localparam int unsigned STATUS_W     = 8;

    // ------------------------------------------------------------------
    // Interface line groups
    // ------------------------------------------------------------------
    localparam int unsigned NUM_SEL  = 4;
    localparam int unsigned NUM_CTRL = 5;
    localparam int unsigned NUM_STAT = 4;
    localparam int unsigned C_STEP   = 0;
    localparam int unsigned C_DIR    = 1;
    localparam int unsigned C_WREN   = 2;
    localparam int unsigned C_WDATA  = 3;
    localparam int unsigned C_SIDE   = 4;
    localparam int unsigned T_INDEX  = 0;
    localparam int unsigned T_TRACK0 = 1;
    localparam int unsigned T_WPROT  = 2;
    localparam int unsigned T_RDATA  = 3;

    localparam logic [NUM_CTRL-1:0] CTRL_IDLE_N = 5'h1F;
    localparam logic [NUM_STAT-1:0] STAT_IDLE_N = 4'hF;
    localparam logic [STATUS_W-1:0] STATUS_RST  = 8'h08;

    // True when any low select line has its strap fitted
    function automatic logic sel_hit(input logic [NUM_SEL-1:0] sel_n,
                                     input logic [NUM_SEL-1:0] straps);
        return |(~sel_n & straps);
    endfunction : sel_hit

endpackage : dosl_pkg

// ==== core/dosl_sel_decode.sv ====
// Select decode of the drive option strap logic: strapped select and drive enable.
// Assumes select lines already synchronous to the core clock.
`timescale 1ns/100ps
`default_nettype none
module dosl_sel_decode
    import dosl_pkg::*;
(
    input  wire logic [NUM_SEL-1:0] sel_n_i,
    input  wire logic [NUM_SEL-1:0] sel_strap_i,
    input  wire logic               fourth_en_i,
    input  wire logic               force_i,
    output var  logic               strapped_o,
    output var  logic               enabled_o
);

    logic [NUM_SEL-1:0] usable_straps;

    always_comb begin
        usable_straps          = sel_strap_i;
        usable_straps[F_SEL_D] = sel_strap_i[F_SEL_D] & fourth_en_i;
        strapped_o             = sel_hit(sel_n_i, usable_straps);
        enabled_o              = strapped_o | force_i;
    end

endmodule : dosl_sel_decode
`default_nettype wire

// ==== core/dosl_top.sv ====
// Drive option strap logic: strap shunt register, select gating and option outputs.
// Assumes all interface inputs synchronous to core_clk_i; open-collector lines
// resolved outside from value and enable.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - The drive answers whichever controller select line has its select strap fitted.
// - The chosen select line passes through its strap to enable the drive logic.
// - With the single-drive strap fitted the logic stays enabled but the LED stays off unless selected.
// - The power-save strap drops stepper holding power while deselected; otherwise it is always held.
// - The standard write strap blocks write flip-flop set/preset only during write-active; the alternate one always.
// - The standard protect strap honours the protect sensor; the alternate one ignores it.
// - The LED follows drive select by default, or the low in-use input with the two alternate straps.
// - The fourth select line counts only while its enable strap is fitted.
// - The door-lock output follows its interface input only with the door-lock strap fitted.
// - While not enabled (no strapped select, no single-drive strap) the control lines and status outputs toward the controller are disabled.
// - With protect honoured, a sensed protected diskette disables write electronics whatever write enable or side say.
module dosl_top
    import dosl_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                rst_b_i,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr_i,
    input  wire logic [DATA_W-1:0]   reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [DATA_W-1:0]   reg_rdata_o,
    // Controller side
    input  wire logic [NUM_SEL-1:0]  sel_n_i,
    input  wire logic [NUM_CTRL-1:0] ctrl_n_i,
    input  wire logic                in_use_n_i,
    input  wire logic                door_lock_n_i,
    output logic      [NUM_STAT-1:0] stat_n_o,
    output logic      [NUM_STAT-1:0] stat_oe_b_o,
    // Drive side
    input  wire logic                write_active_i,
    input  wire logic                wp_sensor_i,
    input  wire logic                index_n_i,
    input  wire logic                track0_n_i,
    input  wire logic                rdata_n_i,
    output logic      [NUM_CTRL-1:0] ctrl_gated_n_o,
    output logic                     write_gate_o,
    output logic                     wff_block_o,
    output logic                     stepper_hold_o,
    output logic                     led_o,
    output logic                     door_lock_o,
    output logic                     drive_enabled_o
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [SHUNT_W-1:0]  shunt_q;
    logic [SHUNT_W-1:0]  shunt_d;
    logic [DATA_W-1:0]   rdata_q;
    logic [DATA_W-1:0]   rdata_d;
    logic [STATUS_W-1:0] status_q;
    logic [STATUS_W-1:0] status_d;

    always_comb begin
        shunt_d = shunt_q;
        rdata_d = '0;
        if (reg_wr_i && reg_addr_i == SHUNT_OFS) begin
            shunt_d = reg_wdata_i[SHUNT_W-1:0];
        end
        if (reg_rd_i) begin
            if (reg_addr_i == SHUNT_OFS) begin
                rdata_d = {{(DATA_W-SHUNT_W){1'b0}}, shunt_q};
            end else if (reg_addr_i == STATUS_OFS) begin
                rdata_d = {{(DATA_W-STATUS_W){1'b0}}, status_q};
            end else begin
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shunt_q <= SHUNT_RST;
            rdata_q <= '0;
        end else begin
            shunt_q <= shunt_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // Strap interpretation
    // ------------------------------------------------------------------
    // Conflicting strap pairs fall to the safer reading: continuous
    // blocking, honoured protect, held stepper, LED from select.
    logic strapped;
    logic enabled;
    logic wff_cont;
    logic wff_std;
    logic prot_ignore;
    logic led_in_use;
    logic power_save;

    dosl_sel_decode u_sel_decode (
        .sel_n_i     (sel_n_i),
        .sel_strap_i (shunt_q[F_SEL_D:F_SEL_A]),
        .fourth_en_i (shunt_q[F_FOURTH_EN]),
        .force_i     (shunt_q[F_FORCE]),
        .strapped_o  (strapped),
        .enabled_o   (enabled)
    );

    always_comb begin
        wff_cont    = shunt_q[F_WFF_CONT];
        wff_std     = shunt_q[F_WFF_STD] & ~shunt_q[F_WFF_CONT];
        prot_ignore = shunt_q[F_PROT_IGN] & ~shunt_q[F_PROT_HON];
        led_in_use  = shunt_q[F_LED_USE_A] & shunt_q[F_LED_USE_B] & ~shunt_q[F_LED_SEL];
        power_save  = shunt_q[F_STEP_SAVE] & ~shunt_q[F_STEP_HOLD];
    end

    // ------------------------------------------------------------------
    // Option outputs
    // ------------------------------------------------------------------
    logic [NUM_CTRL-1:0] ctrl_gated_n_q;
    logic [NUM_CTRL-1:0] ctrl_gated_n_d;
    logic [NUM_STAT-1:0] stat_n_q;
    logic [NUM_STAT-1:0] stat_n_d;
    logic [NUM_STAT-1:0] stat_oe_b_q;
    logic [NUM_STAT-1:0] stat_oe_b_d;
    logic                write_gate_q;
    logic                write_gate_d;
    logic                wff_block_q;
    logic                wff_block_d;
    logic                hold_q;
    logic                hold_d;
    logic                led_q;
    logic                led_d;
    logic                door_q;
    logic                door_d;
    logic                enabled_q;
    logic                wr_inhibit;

    always_comb begin
        wr_inhibit  = wp_sensor_i & ~prot_ignore;
        ctrl_gated_n_d = enabled ? ctrl_n_i : CTRL_IDLE_N;
        stat_n_d    = STAT_IDLE_N;
        if (enabled) begin
            stat_n_d[T_INDEX]  = index_n_i;
            stat_n_d[T_TRACK0] = track0_n_i;
            stat_n_d[T_WPROT]  = ~wr_inhibit;
            stat_n_d[T_RDATA]  = rdata_n_i;
        end
        // Open collector: enable only while pulling low
        stat_oe_b_d  = stat_n_d;
        write_gate_d = enabled & ~ctrl_n_i[C_WREN] & ~wr_inhibit;
        wff_block_d  = wff_cont | (wff_std & write_active_i);
        hold_d       = ~power_save | enabled;
        led_d        = led_in_use ? ~in_use_n_i : strapped;
        door_d       = shunt_q[F_DOOR_LOCK] & ~door_lock_n_i;
        status_d     = '0;
        status_d[S_ENABLED]    = enabled;
        status_d[S_STRAPPED]   = strapped;
        status_d[S_LED]        = led_d;
        status_d[S_STEP_HOLD]  = hold_d;
        status_d[S_WFF_BLOCK]  = wff_block_d;
        status_d[S_WR_INHIBIT] = wr_inhibit;
        status_d[S_WR_GATE]    = write_gate_d;
        status_d[S_DOOR_LOCK]  = door_d;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_gated_n_q <= CTRL_IDLE_N;
            stat_n_q       <= STAT_IDLE_N;
            stat_oe_b_q    <= STAT_IDLE_N;
            write_gate_q   <= 1'b0;
            wff_block_q    <= 1'b0;
            hold_q         <= 1'b1;
            led_q          <= 1'b0;
            door_q         <= 1'b0;
            enabled_q      <= 1'b0;
            status_q       <= STATUS_RST;
        end else begin
            ctrl_gated_n_q <= ctrl_gated_n_d;
            stat_n_q       <= stat_n_d;
            stat_oe_b_q    <= stat_oe_b_d;
            write_gate_q   <= write_gate_d;
            wff_block_q    <= wff_block_d;
            hold_q         <= hold_d;
            led_q          <= led_d;
            door_q         <= door_d;
            enabled_q      <= enabled;
            status_q       <= status_d;
        end
    end

    assign ctrl_gated_n_o  = ctrl_gated_n_q;
    assign stat_n_o        = stat_n_q;
    assign stat_oe_b_o     = stat_oe_b_q;
    assign write_gate_o    = write_gate_q;
    assign wff_block_o     = wff_block_q;
    assign stepper_hold_o  = hold_q;
    assign led_o           = led_q;
    assign door_lock_o     = door_q;
    assign drive_enabled_o = enabled_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Outputs lag by one flop, so most checks look one cycle on
    chk_strap_select_hit: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (!sel_n_i[0] && shunt_q[F_SEL_A]) |=> drive_enabled_o)
        else $error("Strapped select line did not enable drive");

    chk_unstrapped_ignored: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (shunt_q[F_FORCE] == 1'b0 && !led_in_use &&
         ((~sel_n_i & shunt_q[F_SEL_D:F_SEL_A]) == '0))
        |=> !drive_enabled_o && !led_o ##0 ctrl_gated_n_o == CTRL_IDLE_N)
        else $error("Drive enabled without a strapped select");

    chk_force_led_off: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (shunt_q[F_FORCE] && !led_in_use && !strapped) |=> drive_enabled_o && !led_o)
        else $error("Forced enable lit the LED or failed to enable");

    chk_stepper_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 stepper_hold_o == (!$past(power_save) || $past(enabled)))
        else $error("Stepper holding power wrong for strap and select");

    chk_wff_block_mode: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (wff_std && !write_active_i) |=> !wff_block_o)
        else $error("Write flip-flop blocked outside write-active");

    chk_wff_cont_block: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        shunt_q[F_WFF_CONT] [*2] |-> wff_block_o)
        else $error("Continuous write flip-flop block missing");

    chk_protect_ignored: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (prot_ignore && enabled && !ctrl_n_i[C_WREN]) |=> write_gate_o && stat_n_o[T_WPROT])
        else $error("Ignored protect sensor still inhibited writing");

    chk_led_in_use: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        led_in_use |=> led_o == !$past(in_use_n_i))
        else $error("LED did not follow in-use input");

    chk_fourth_disabled: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (!shunt_q[F_FOURTH_EN] && !shunt_q[F_FORCE] && sel_n_i[2:0] == 3'b111)
        |=> !drive_enabled_o)
        else $error("Fourth select line used without enable strap");

    chk_door_lock_gate: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !shunt_q[F_DOOR_LOCK] |=> !door_lock_o)
        else $error("Door lock driven without its strap");

    chk_status_released: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !drive_enabled_o |-> (stat_oe_b_o == STAT_IDLE_N) && !write_gate_o)
        else $error("Status lines driven while deselected");

    chk_protect_inhibit: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (wp_sensor_i && !prot_ignore) |=> !write_gate_o && !stat_n_o[T_WPROT] == $past(enabled))
        else $error("Protected diskette did not inhibit writing");

    chk_select_or: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 drive_enabled_o == ($past(strapped) || $past(shunt_q[F_FORCE])))
        else $error("Drive enable is not the OR of strapped selects");

    chk_fourth_select: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (shunt_q[F_FOURTH_EN] && shunt_q[F_SEL_D] && !sel_n_i[F_SEL_D]) |=> drive_enabled_o)
        else $error("Fitted fourth select line did not enable drive");

    chk_ctrl_pass_through: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        enabled |=> ctrl_gated_n_o == $past(ctrl_n_i))
        else $error("Control lines not passed while selected");

    chk_door_follow: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        shunt_q[F_DOOR_LOCK] |=> door_lock_o == !$past(door_lock_n_i))
        else $error("Door lock did not follow its input");

    chk_wff_std_active: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (wff_std && write_active_i) |=> wff_block_o)
        else $error("Write flip-flop not blocked during write-active");

    chk_power_save_drop: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (power_save && !enabled) |=> !stepper_hold_o)
        else $error("Stepper held while deselected in power save");

    chk_read_one_cycle: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !reg_rd_i |=> reg_rdata_o == '0)
        else $error("Read data present outside its cycle");

endmodule : dosl_top
`default_nettype wire

// ==== verif/dosl_host_model.sv ====
// Host controller model for the drive option strap bench: select, control and option lines.
// Assumes the bench calls drive() from its main sequence; status lines are pulled up.
`timescale 1ns/100ps
`default_nettype none
module dosl_host_model
    import dosl_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic [NUM_STAT-1:0] stat_oe_b_i,
    output var  logic [NUM_SEL-1:0]  sel_n_o,
    output var  logic [NUM_CTRL-1:0] ctrl_n_o,
    output var  logic                in_use_n_o,
    output var  logic                door_lock_n_o,
    output var  logic [NUM_STAT-1:0] stat_line_o
);
    // ------------------------------------------------------------------
    // Open-collector resolution
    // ------------------------------------------------------------------
    // Terminator pull-up: a released line reads high, never the last value
    always_comb begin
        for (int k = 0; k < NUM_STAT; k++) begin
            stat_line_o[k] = stat_oe_b_i[k] ? 1'b1 : 1'b0;
        end
    end

    initial begin
        sel_n_o       = '1;
        ctrl_n_o      = CTRL_IDLE_N;
        in_use_n_o    = 1'b1;
        door_lock_n_o = 1'b1;
    end

    // Never pulls two select lines low: callers pass one-hot-low patterns
    task automatic drive(input logic [NUM_SEL-1:0] sel, input logic [NUM_CTRL-1:0] ctrl,
                         input logic iu, input logic dl);
        @(posedge core_clk_i);
        sel_n_o       <= sel;
        ctrl_n_o      <= ctrl;
        in_use_n_o    <= iu;
        door_lock_n_o <= dl;
    endtask : drive
endmodule : dosl_host_model
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench of the drive option strap logic: register tasks and strap scenarios.
// Assumes dosl_top and dosl_host_model; expectations come from strap settings and the driven line levels.
`timescale 1ns/100ps
`default_nettype none
module tb
    import dosl_pkg::*;
;
    logic                core_clk_i;
    logic                rst_b_i;
    logic [ADDR_W-1:0]   reg_addr_i;
    logic [DATA_W-1:0]   reg_wdata_i;
    logic                reg_wr_i;
    logic                reg_rd_i;
    logic [DATA_W-1:0]   reg_rdata_o;
    logic [NUM_SEL-1:0]  sel_n;
    logic [NUM_CTRL-1:0] ctrl_n;
    logic                in_use_n;
    logic                door_lock_n;
    logic [NUM_STAT-1:0] stat_n_o;
    logic [NUM_STAT-1:0] stat_oe_b_o;
    logic [NUM_STAT-1:0] stat_line;
    logic                write_active_i;
    logic                wp_sensor_i;
    logic                index_n_i;
    logic                track0_n_i;
    logic                rdata_n_i;
    logic [NUM_CTRL-1:0] ctrl_gated_n_o;
    logic                write_gate_o;
    logic                wff_block_o;
    logic                stepper_hold_o;
    logic                led_o;
    logic                door_lock_o;
    logic                drive_enabled_o;
    logic [DATA_W-1:0]   rd;
    int                  miscompares = 0;
    int                  tests_run   = 0;
    int                  cycles      = 0;
    localparam logic [SHUNT_W-1:0] BASE       = 16'h92A0;
    localparam int unsigned        CYCLE_CEIL = 5000;

    dosl_top dut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sel_n_i(sel_n), .ctrl_n_i(ctrl_n), .in_use_n_i(in_use_n),
        .door_lock_n_i(door_lock_n), .stat_n_o(stat_n_o), .stat_oe_b_o(stat_oe_b_o),
        .write_active_i(write_active_i), .wp_sensor_i(wp_sensor_i), .index_n_i(index_n_i),
        .track0_n_i(track0_n_i), .rdata_n_i(rdata_n_i), .ctrl_gated_n_o(ctrl_gated_n_o),
        .write_gate_o(write_gate_o), .wff_block_o(wff_block_o),
        .stepper_hold_o(stepper_hold_o), .led_o(led_o), .door_lock_o(door_lock_o),
        .drive_enabled_o(drive_enabled_o)
    );

    dosl_host_model host (
        .core_clk_i(core_clk_i), .stat_oe_b_i(stat_oe_b_o), .sel_n_o(sel_n),
        .ctrl_n_o(ctrl_n), .in_use_n_o(in_use_n), .door_lock_n_o(door_lock_n),
        .stat_line_o(stat_line)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------------
    // Hang guard and closing report
    // ------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == CYCLE_CEIL) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, miscompares);
    endtask : end_test

    // ------------------------------------------------------------------
    // Register port: one-cycle strobes, read data in the following cycle
    // ------------------------------------------------------------------
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : reg_rd

    // Straps, host lines and drive-side levels, then wait past the one-cycle latency
    task automatic apply(input logic [SHUNT_W-1:0] s, input logic [NUM_SEL-1:0] sel,
                         input logic [NUM_CTRL-1:0] ctrl, input logic iu, input logic dl,
                         input logic wa, input logic wp);
        reg_wr(SHUNT_OFS, {16'h0000, s});
        host.drive(sel, ctrl, iu, dl);
        write_active_i <= wa;
        wp_sensor_i    <= wp;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask : apply

    initial begin
        rst_b_i        = 1'b0;
        reg_addr_i     = '0;
        reg_wdata_i    = '0;
        reg_wr_i       = 1'b0;
        reg_rd_i       = 1'b0;
        write_active_i = 1'b0;
        wp_sensor_i    = 1'b0;
        index_n_i      = 1'b1;
        track0_n_i     = 1'b1;
        rdata_n_i      = 1'b1;
        repeat (16) @(posedge core_clk_i);
        rst_b_i <= 1'b1;

        reg_rd(SHUNT_OFS, rd);
        chk("shunt reset", 32'h0000_92A1, rd);
        reg_rd(STATUS_OFS, rd);
        chk("status reset", 32'h0000_0008, rd);
        reg_wr(STATUS_OFS, 32'hFFFF_FFFF);
        reg_rd(STATUS_OFS, rd);
        chk("status read-only", 32'h0000_0008, rd);
        reg_wr(8'h10, 32'h0000_0000);
        reg_rd(8'h10, rd);
        chk("unmapped read", 32'h0000_0000, rd);
        reg_wr(SHUNT_OFS, 32'hFFFF_1234);
        reg_rd(SHUNT_OFS, rd);
        chk("shunt readback", 32'h0000_1234, rd);
        end_test("registers");

        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
                apply(BASE | (16'h0001 << i), ~(4'h1 << j), CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
                chk("drive_enabled", i == j, drive_enabled_o);
                chk("led from select", i == j, led_o);
            end
        end
        apply(16'h82A8, 4'h7, CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("fourth line off", 1'b0, drive_enabled_o);
        apply(16'h92B0, 4'hF, CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("forced enable", 1'b1, drive_enabled_o);
        chk("forced led", 1'b0, led_o);
        end_test("select");

        @(posedge core_clk_i);
        index_n_i <= 1'b0;
        rdata_n_i <= 1'b0;
        apply(16'h92A1, 4'hE, 5'h0A, 1'b1, 1'b1, 1'b0, 1'b1);
        chk("ctrl_gated live", 5'h0A, ctrl_gated_n_o);
        chk("stat_n live", 4'h2, stat_n_o);
        chk("stat line live", 4'h2, stat_line);
        chk("write_gate protected", 1'b0, write_gate_o);
        reg_rd(STATUS_OFS, rd);
        chk("status live", 32'h0000_002F, rd);
        apply(16'h92A1, 4'hF, 5'h0A, 1'b1, 1'b1, 1'b0, 1'b1);
        chk("ctrl_gated idle", 5'h1F, ctrl_gated_n_o);
        chk("stat_oe_b idle", 4'hF, stat_oe_b_o);
        chk("stat line idle", 4'hF, stat_line);
        chk("write_gate idle", 1'b0, write_gate_o);
        apply(16'h9321, 4'hE, 5'h0A, 1'b1, 1'b1, 1'b0, 1'b1);
        chk("write_gate ignored", 1'b1, write_gate_o);
        apply(16'h92A1, 4'hE, 5'h0A, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("write_gate clear", 1'b1, write_gate_o);
        end_test("gating");

        apply(16'h92A1, 4'hF, CTRL_IDLE_N, 1'b1, 1'b1, 1'b1, 1'b0);
        chk("wff std active", 1'b1, wff_block_o);
        apply(16'h92A1, 4'hF, CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("wff std idle", 1'b0, wff_block_o);
        apply(16'h92C1, 4'hF, CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("wff continuous", 1'b1, wff_block_o);
        chk("stepper held", 1'b1, stepper_hold_o);
        apply(16'h52A1, 4'hF, CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("stepper saved", 1'b0, stepper_hold_o);
        apply(16'h52A1, 4'hE, CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("stepper reselected", 1'b1, stepper_hold_o);
        end_test("options");

        apply(16'h9CA1, 4'hE, CTRL_IDLE_N, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("led in use", 1'b1, led_o);
        apply(16'h9CA1, 4'hE, CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("led not in use", 1'b0, led_o);
        apply(16'h92A1, 4'hF, CTRL_IDLE_N, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("door unstrapped", 1'b0, door_lock_o);
        apply(16'hB2A1, 4'hF, CTRL_IDLE_N, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("door strapped", 1'b1, door_lock_o);
        apply(16'hB2A1, 4'hF, CTRL_IDLE_N, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("door released", 1'b0, door_lock_o);
        end_test("indicator and door");

        report_and_stop();
    end
endmodule : tb
`default_nettype wire
